/* core/sram_ctl_pkg.sv */
// constants for the static memory module controller
// assumes a 200 MHz system clock and the fastest speed grade of the module
package sram_ctl_pkg;
  // clock period in picoseconds
  localparam int CLK_PERIOD_PS = 5000;
  // module organisation
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  // times in nanoseconds, as printed for the fastest grade
  localparam int T_READ_CYCLE_NS = 20;
  localparam int T_WRITE_CYCLE_NS = 20;
  localparam int T_ADDR_ACCESS_NS = 20;
  localparam int T_GATE_ACCESS_NS = 10;
  localparam int T_WRITE_PULSE_NS = 15;
  localparam int T_WRITE_PULSE_GH_NS = 12;
  localparam int T_FLOAT_NS = 8;
  localparam int T_WRITE_RECOVER_NS = 4;
  // least times round up, access waits are least times for the host too
  localparam int C_READ_CYCLE =
    (T_READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_ADDR_ACCESS =
    (T_ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WRITE_CYCLE =
    (T_WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WRITE_PULSE =
    (T_WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WRITE_PULSE_GH =
    (T_WRITE_PULSE_GH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_FLOAT =
    (T_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int C_WRITE_RECOVER =
    (T_WRITE_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // width of the phase counter
  localparam int CNT_W = 4;
  // controller states, gray coded along idle-read-write-write hold-recovery
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_WR = 3'b011,
    ST_WR_HOLD = 3'b010,
    ST_REC = 3'b110
  } state_t;
endpackage : sram_ctl_pkg

/* core/sram_sync3.sv */
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to sys_clk
module sram_sync3 #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw and settled value
  input wire logic [W-1:0] raw,
  output logic [W-1:0] settled
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } sync_t;
  sync_t st;
  sync_t next_st;

  // shift chain; first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts when stages two and three agree, bit by bit
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.out[i] = st.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign settled = st.out;
endmodule : sram_sync3

/* core/sram_host_ctl.sv */
// host controller for a 64k x 32 asynchronous static memory module
// assumes the module pins are wired straight to these ports and a wrapper
// resolves the shared data bus from the per-bit output enables
module sram_host_ctl
  import sram_ctl_pkg::*;
#(
  parameter int AW = sram_ctl_pkg::ADDR_W,
  parameter int DW = sram_ctl_pkg::DATA_W,
  parameter int NL = sram_ctl_pkg::LANES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_gate_off,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [NL-1:0] req_lanes,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // module pins
  output logic [AW-1:0] mem_addr,
  output logic [NL-1:0] lane_on_n_bus,
  output logic gate_n,
  output logic write_n,
  input wire logic [DW-1:0] shared_data_bus_in,
  output logic [DW-1:0] shared_data_bus_out,
  output logic [DW-1:0] shared_data_bus_oe_n
);
  import sram_ctl_pkg::*;

  // elaboration check: lanes must tile the word, counter must reach
  // the read wait; anything else is refused before it can misbehave
  // fixed address width; word width set by the lanes
  if (AW != ADDR_W || DW != NL * LANE_W || NL < 1 ||
      C_ADDR_ACCESS + 3 >= (1 << CNT_W)) begin : g_bad_width
    $error("sram_host_ctl: unsupported width parameters");
  end

  // all controller state in one record
  typedef struct packed {
    state_t fsm;
    logic [CNT_W-1:0] cnt;
    logic wr_gate_off;
    logic [NL-1:0] lanes;
    logic ready;
    logic rsp;
    logic [DW-1:0] rdata;
    logic [AW-1:0] addr;
    logic [NL-1:0] lane_n;
    logic gate_n;
    logic write_n;
    logic [DW-1:0] dout;
    logic [DW-1:0] oe_n;
  } ctl_t;
  ctl_t st;
  ctl_t next_st;

  // settled copy of the data bus
  // lags the pins by four cycles; the read wait covers it
  logic [DW-1:0] bus_sync;

  // bus input crosses in from the asynchronous module
  sram_sync3 #(
    .W(DW)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw(shared_data_bus_in),
    .settled(bus_sync)
  );

  // lane mask widened to bit level
  function automatic logic [DW-1:0] lane_bits(input logic [NL-1:0] l);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < NL; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{l[i]}};
    end
    return m;
  endfunction : lane_bits

  // sequencing of one access at a time
  always_comb begin
    next_st = st;
    next_st.rsp = 1'b0;
    case (st.fsm)
      ST_IDLE: begin
        // idle: advertise readiness, take one request
        next_st.ready = 1'b1;
        if (req_valid && st.ready) begin
          next_st.ready = 1'b0;
          // address presented with the lane enables
          next_st.addr = req_addr;
          next_st.lanes = req_lanes;
          next_st.lane_n = ~req_lanes;
          next_st.cnt = '0;
          next_st.wr_gate_off = req_gate_off;
          if (req_write) begin
            // gate held high so output never fights data
            next_st.gate_n = 1'b1;
            // strobe falls with the lanes, host drives the enabled lanes
            next_st.write_n = 1'b0;
            next_st.dout = req_wdata;
            next_st.oe_n = ~lane_bits(req_lanes);
            next_st.fsm = ST_WR;
          end else begin
            next_st.write_n = 1'b1;
            // lanes and gate stand while the address holds
            // gate stays high if caller wants no data
            next_st.gate_n = req_gate_off;
            next_st.oe_n = '1;
            next_st.fsm = ST_RD;
          end
        end
      end
      ST_RD: begin
        next_st.cnt = st.cnt + 1'b1;
        // wait address access plus synchroniser depth
        // address held for the full read cycle
        if (int'(st.cnt) >= C_ADDR_ACCESS + 3 &&
            int'(st.cnt) >= C_READ_CYCLE - 1) begin
          // data taken before the address moves
          next_st.rdata = st.gate_n ? '0 : (bus_sync & lane_bits(st.lanes));
          next_st.rsp = 1'b1;
          next_st.lane_n = '1;
          // release gate with lanes; float delay is next phase
          next_st.gate_n = 1'b1;
          next_st.cnt = '0;
          next_st.fsm = ST_REC;
        end
      end
      ST_WR: begin
        next_st.cnt = st.cnt + 1'b1;
        // strobe low time, gate-high minimum when wr_gate_off is set; both round to three cycles
        if (int'(st.cnt) >= (st.wr_gate_off ? C_WRITE_PULSE_GH :
                                             C_WRITE_PULSE) - 1) begin
          next_st.write_n = 1'b1;
          next_st.lane_n = '1;
          next_st.fsm = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // data held one cycle past the strobe end
        next_st.cnt = st.cnt + 1'b1;
        next_st.oe_n = '1;
        next_st.rsp = 1'b1;
        next_st.fsm = ST_REC;
      end
      ST_REC: begin
        next_st.cnt = st.cnt + 1'b1;
        // cycle spacing; float and recovery gap
        if (int'(st.cnt) >= C_WRITE_CYCLE - 1 &&
            int'(st.cnt) >= C_FLOAT + C_WRITE_RECOVER) begin
          next_st.cnt = '0;
          next_st.ready = 1'b1;
          next_st.fsm = ST_IDLE;
        end
      end
      default: begin
        // stray codes fall back to idle
        next_st.fsm = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // pins parked inactive so the module floats
      st <= '0;
      st.fsm <= ST_IDLE;
      st.lane_n <= '1;
      st.gate_n <= 1'b1;
      st.write_n <= 1'b1;
      st.oe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the record
  assign req_ready = st.ready;
  assign rsp_valid = st.rsp;
  assign rsp_rdata = st.rdata;
  assign mem_addr = st.addr;
  assign lane_on_n_bus = st.lane_n;
  assign gate_n = st.gate_n;
  assign write_n = st.write_n;
  assign shared_data_bus_out = st.dout;
  assign shared_data_bus_oe_n = st.oe_n;
endmodule : sram_host_ctl

/* verification/sram_host_ctl_checker.sv */
// assertions on the host controller pins
// assumes a bind onto the top module, one clock domain
module sram_host_ctl_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // answer
  input wire logic rsp_valid,
  // module pins
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lane_on_n_bus,
  input wire logic gate_n,
  input wire logic write_n,
  input wire logic [31:0] shared_data_bus_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [3:0] gap; // cycles since the address last moved
  // saturates, so long idles never wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 4'hf;
    end else if ($changed(mem_addr)) begin
      gap <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
  sequence s_strobe;
    !write_n [*3] ##1 write_n;
  endsequence
  sequence s_read;
    !gate_n [*8] ##1 rsp_valid;
  endsequence
  // read address must stand four cycles, 20 ns
  sequence s_addr_still;
    $stable(mem_addr) [*4];
  endsequence
  AST_WR_PULSE: assert property ($fell(write_n) |-> s_strobe)
    else $error("write strobe width wrong");
  AST_LANE_FALL: assert property ($fell(write_n) |->
    $past(lane_on_n_bus) == 4'hf)
    else $error("lanes fell before strobe");
  AST_LANE_RISE: assert property ($rose(write_n) |->
    lane_on_n_bus == 4'hf)
    else $error("lanes still on after strobe");
  AST_GATE_WR: assert property (!write_n |-> gate_n)
    else $error("gate low during write");
  AST_NO_CLASH: assert property (shared_data_bus_oe_n != '1 |-> gate_n)
    else $error("host drives while module may");
  AST_DATA_HOLD: assert property ($rose(write_n) |->
    shared_data_bus_oe_n != '1 ##1 shared_data_bus_oe_n == '1)
    else $error("write data hold wrong");
  AST_RD_WAIT: assert property ($fell(gate_n) |-> s_read)
    else $error("read wait wrong");
  AST_REL: assert property (rsp_valid |->
    lane_on_n_bus == 4'hf && gate_n)
    else $error("pins not released with answer");
  AST_ADDR_GAP: assert property ($changed(mem_addr) |-> gap >= 4'h3)
    else $error("address moved too soon");
  AST_ADDR_HOLD: assert property (lane_on_n_bus != 4'hf &&
    $past(lane_on_n_bus) != 4'hf |-> $stable(mem_addr))
    else $error("address moved under lanes");
  AST_RD_ADDR: assert property (write_n && lane_on_n_bus != 4'hf &&
    $past(lane_on_n_bus) == 4'hf |-> ##1 s_addr_still)
    else $error("read address not held");
endmodule : sram_host_ctl_checker

/* verification/sram_module_model.sv */
// behavioural 64k x 32 memory module with byte lanes
// assumes host pins wired straight in; no timing modelled
module sram_module_model (
  // clock and host pins
  input wire logic sys_clk,
  input wire logic [15:0] addr,
  input wire logic [3:0] lane_n,
  input wire logic gate_n,
  input wire logic write_n,
  input wire logic [31:0] dout,
  input wire logic [31:0] oe_n,
  // resolved bus
  output logic [31:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [65536];
  logic [31:0] last = 32'h0f0f0f0f; // last bus value seen while gate is low and write is high
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!oe_n[i]) bus[i] = dout[i];
      else if (!lane_n[i/8] && !gate_n && write_n) bus[i] = mem[addr][i];
      else bus[i] = ~last[i]; // no pull, so show junk
    end
  end
  always @(posedge sys_clk) begin
    for (int l = 0; l < 4; l++) begin
      if (!write_n && !lane_n[l]) mem[addr][8*l+:8] <= bus[8*l+:8];
    end
    if (!gate_n && write_n) last <= bus;
  end
endmodule : sram_module_model

/* verification/sram_host_ctl_tb.sv */
// self-checking bench for the memory host controller
// assumes the module model resolves the shared bus
module sram_host_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ctl_pkg::*;
  logic sys_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
  logic req_gate_off = 0, req_ready, rsp_valid, gate_n, write_n;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, dout, oe_n, bus, rdata;
  logic [LANES-1:0] req_lanes = '0, lane_on_n_bus;
  logic [31:0] exp;
  int failures = 0, n_checks = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  sram_host_ctl DUT (.sys_clk, .rst_n, .req_valid, .req_write,
    .req_gate_off, .req_addr, .req_wdata, .req_lanes, .req_ready,
    .rsp_valid, .rsp_rdata, .mem_addr, .lane_on_n_bus, .gate_n,
    .write_n, .shared_data_bus_in(bus), .shared_data_bus_out(dout),
    .shared_data_bus_oe_n(oe_n));
  sram_module_model mem_model (.sys_clk, .addr(mem_addr),
    .lane_n(lane_on_n_bus), .gate_n, .write_n, .dout, .oe_n, .bus);
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : check
  // one request, held until taken, then wait for the answer
  task automatic op(input logic w, g, input logic [15:0] a,
    input logic [31:0] d, input logic [3:0] l);
    int n = 0;
    req_valid = 1;
    req_write = w;
    req_gate_off = g;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    while (req_ready !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    tick;
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 80) begin
      tick;
      n++;
    end
    // a request that never answers counts as a mismatch
    if (n >= 80) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, rsp_valid);
    end
    rdata = rsp_rdata;
  endtask : op
  task automatic t_lanes;
    op(1, 0, 16'hffff, 32'h11223344, 4'hf);
    op(1, 0, 16'hffff, 32'haabbccdd, 4'h5);
    op(0, 0, 16'hffff, 32'h0, 4'hf);
    check(32'h11bb33dd, rdata);
    op(0, 0, 16'hffff, 32'h0, 4'ha);
    check(32'h11003300, rdata);
  endtask : t_lanes
  task automatic t_gate;
    op(1, 1, 16'h0000, 32'hc0ffee01, 4'hf);
    op(0, 1, 16'h0000, 32'h0, 4'hf);
    check(32'h0, rdata);
    op(0, 0, 16'h0000, 32'h0, 4'hf);
    check(32'hc0ffee01, rdata);
  endtask : t_gate
  task automatic t_walk;
    exp = 32'h0;
    op(1, 0, 16'h0010, 32'h0, 4'hf);
    for (int l = 0; l < 4; l++) begin
      op(1, 0, 16'h0010, 32'hffffffff, 4'h1 << l);
      exp = exp | (32'hff << (8 * l));
      op(0, 0, 16'h0010, 32'h0, 4'hf);
      check(exp, rdata);
    end
  endtask : t_walk
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // hang guard, far above the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1;
    tick;
    tick;
    t_lanes;
    t_gate;
    t_walk;
    test_done;
  end
endmodule : sram_host_ctl_tb
bind sram_host_ctl sram_host_ctl_checker chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .rsp_valid(rsp_valid),
  .mem_addr(mem_addr),
  .lane_on_n_bus(lane_on_n_bus),
  .gate_n(gate_n),
  .write_n(write_n),
  .shared_data_bus_oe_n(shared_data_bus_oe_n)
);
